// file: logic/pif_flags_top.sv
// module: peripheral interrupt flag registers behind a wishbone slave
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module pif_flags_top
    import pif_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // peripheral event pulses
    input wire logic adc_done_i,
    input wire logic ssp_done_i,
    input wire logic capture_i,
    input wire logic compare_match_i,
    input wire logic period_match_i,
    input wire logic timer_overflow_i,
    input wire logic osc_fail_i,
    input wire logic nv_write_done_i,
    // comparator output levels
    input wire logic first_comparator_output_i,
    input wire logic second_comparator_output_i,
    // serial receive side
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    // serial transmit side
    input wire logic tx_take_i,
    output logic tx_full_o,
    output logic [7:0] tx_data_o,
    // interrupt request
    output logic irq_o
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
        reg_hit = (adr[7:2] == off[7:2]);
    endfunction

    logic [7:0] flags_a_r;
    logic [7:0] flags_b_r;
    logic [7:0] en_a_r;
    logic [7:0] en_b_r;
    logic [7:0] ctrl_r;
    logic [7:0] rx_data_r;
    logic rx_full_r;
    logic rx_ovr_r;
    logic [7:0] tx_data_r;
    logic tx_full_r;
    logic ack_r;
    logic [31:0] dat_r;

    logic req;
    logic wr_stb;
    logic rd_stb;
    logic lane0;
    logic hit_flags_a;
    logic hit_flags_b;
    logic hit_en_a;
    logic hit_en_b;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_rx;
    logic hit_tx;
    logic hit_pend;
    logic [7:0] flags_a_view;
    logic [7:0] flags_b_view;
    logic [7:0] stat_view;
    logic [7:0] pend_a;
    logic [7:0] pend_b;
    logic [7:0] rd_byte;
    logic [7:0] flags_a_nxt;
    logic [7:0] flags_b_nxt;

    pif_evt_if evt();

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    assign evt.adc_done = adc_done_i;
    assign evt.ssp_done = ssp_done_i;
    assign evt.capture = capture_i;
    assign evt.match = compare_match_i;
    assign evt.period_match = period_match_i;
    assign evt.overflow = timer_overflow_i;
    assign evt.osc_fail = osc_fail_i;
    assign evt.nv_done = nv_write_done_i;
    assign evt.cmp1_out = first_comparator_output_i;
    assign evt.cmp2_out = second_comparator_output_i;
    assign evt.ccp_mode =
        pif_ccp_mode_e'(ctrl_r[PIF_CTRL_MODE_LSB +: 2]);

    pif_event_detect u_detect (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .evt(evt)
    );

    // ------------------------------------------------------------
    // bus handshake: one wait state, ack for every address
    // ------------------------------------------------------------
    assign req = wb_cyc_i & wb_stb_i;
    // side effects happen at the edge where the master sees ack
    assign wr_stb = req & wb_we_i & ack_r;
    assign rd_stb = req & ~wb_we_i & ack_r;
    assign lane0 = wb_sel_i[0];

    assign hit_flags_a = reg_hit(wb_adr_i, PIF_OFF_FLAGS_A);
    assign hit_flags_b = reg_hit(wb_adr_i, PIF_OFF_FLAGS_B);
    assign hit_en_a = reg_hit(wb_adr_i, PIF_OFF_EN_A);
    assign hit_en_b = reg_hit(wb_adr_i, PIF_OFF_EN_B);
    assign hit_ctrl = reg_hit(wb_adr_i, PIF_OFF_CTRL);
    assign hit_stat = reg_hit(wb_adr_i, PIF_OFF_STAT);
    assign hit_rx = reg_hit(wb_adr_i, PIF_OFF_RXDATA);
    assign hit_tx = reg_hit(wb_adr_i, PIF_OFF_TXDATA);
    assign hit_pend = reg_hit(wb_adr_i, PIF_OFF_PEND);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
        end else begin
            // drop ack after one cycle so back-to-back cycles stay apart
            ack_r <= req & ~ack_r;
        end
    end

    assign wb_ack_o = ack_r;

    // ------------------------------------------------------------
    // read views
    // ------------------------------------------------------------
    always_comb begin
        flags_a_view = flags_a_r & PIF_MASK_A;
        flags_a_view[PIF_BIT_RX] = rx_full_r;
        flags_a_view[PIF_BIT_TX] = ~tx_full_r;
    end

    assign flags_b_view = flags_b_r & PIF_MASK_B;

    always_comb begin
        stat_view = 8'h00;
        stat_view[PIF_STAT_FIRST_COMPARATOR_OUTPUT] = first_comparator_output_i;
        stat_view[PIF_STAT_SECOND_COMPARATOR_OUTPUT] = second_comparator_output_i;
        stat_view[PIF_STAT_RXOVR] = rx_ovr_r;
        stat_view[PIF_STAT_TXFULL] = tx_full_r;
        stat_view[PIF_STAT_MODE_LSB +: 2] =
            ctrl_r[PIF_CTRL_MODE_LSB +: 2];
    end

    assign pend_a = flags_a_view & en_a_r & PIF_MASK_A;
    assign pend_b = flags_b_view & en_b_r & PIF_MASK_B;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_flags_a) begin
            rd_byte = flags_a_view;
        end else if (hit_flags_b) begin
            rd_byte = flags_b_view;
        end else if (hit_en_a) begin
            rd_byte = en_a_r & PIF_MASK_A;
        end else if (hit_en_b) begin
            rd_byte = en_b_r & PIF_MASK_B;
        end else if (hit_ctrl) begin
            rd_byte = ctrl_r;
        end else if (hit_stat) begin
            rd_byte = stat_view;
        end else if (hit_rx) begin
            rd_byte = rx_data_r;
        end else if (hit_tx) begin
            rd_byte = tx_data_r;
        end else if (hit_pend) begin
            rd_byte = pend_a | pend_b;
        end
    end

    // read data is caught one edge ahead of the ack it goes with
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req & ~wb_we_i & ~ack_r) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_dat_o = dat_r;

    // ------------------------------------------------------------
    // flag register a: set wins over a software write
    // ------------------------------------------------------------
    always_comb begin
        flags_a_nxt = flags_a_r;
        if (wr_stb & lane0 & hit_flags_a) begin
            // serial flags are not stored here, so writes skip them
            flags_a_nxt = (flags_a_r & ~PIF_WMASK_A) |
                          (wb_dat_i[7:0] & PIF_WMASK_A);
        end
        flags_a_nxt = (flags_a_nxt | evt.set_a) & PIF_WMASK_A;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_a_r <= PIF_RST_FLAGS;
        end else begin
            flags_a_r <= flags_a_nxt;
        end
    end

    // ------------------------------------------------------------
    // flag register b: set wins over a software write
    // ------------------------------------------------------------
    always_comb begin
        flags_b_nxt = flags_b_r;
        if (wr_stb & lane0 & hit_flags_b) begin
            flags_b_nxt = wb_dat_i[7:0];
        end
        flags_b_nxt = (flags_b_nxt | evt.set_b) & PIF_MASK_B;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_b_r <= PIF_RST_FLAGS;
        end else begin
            flags_b_r <= flags_b_nxt;
        end
    end

    // ------------------------------------------------------------
    // enables and control
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_a_r <= PIF_RST_EN;
            en_b_r <= PIF_RST_EN;
        end else if (wr_stb & lane0) begin
            if (hit_en_a) begin
                en_a_r <= wb_dat_i[7:0] & PIF_MASK_A;
            end
            if (hit_en_b) begin
                en_b_r <= wb_dat_i[7:0] & PIF_MASK_B;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= PIF_RST_CTRL;
        end else if (wr_stb & lane0 & hit_ctrl) begin
            // unused control bits are kept at zero
            ctrl_r <= wb_dat_i[7:0] & {2'b11, 4'h0, 2'b11};
        end
    end

    // ------------------------------------------------------------
    // receive holding register
    // ------------------------------------------------------------
    // a byte arriving while full is dropped and marks overrun; the
    // held byte is kept so software still sees the older data
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_full_r <= 1'b0;
            rx_data_r <= PIF_RST_DATA;
        end else begin
            if (rx_valid_i & (~rx_full_r | (rd_stb & hit_rx))) begin
                rx_full_r <= 1'b1;
                rx_data_r <= rx_data_i;
            end else if (rd_stb & hit_rx) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_ovr_r <= 1'b0;
        end else if (rx_valid_i & rx_full_r & ~(rd_stb & hit_rx)) begin
            rx_ovr_r <= 1'b1;
        end else if (wr_stb & lane0 & hit_stat &
                     wb_dat_i[PIF_STAT_RXOVR]) begin
            rx_ovr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmit holding register
    // ------------------------------------------------------------
    // a write while full overwrites the waiting byte; software is
    // expected to wait for the empty flag first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_full_r <= 1'b0;
            tx_data_r <= PIF_RST_DATA;
        end else begin
            if (wr_stb & lane0 & hit_tx) begin
                tx_full_r <= 1'b1;
                tx_data_r <= wb_dat_i[7:0];
            end else if (tx_take_i) begin
                tx_full_r <= 1'b0;
            end
        end
    end

    assign tx_full_o = tx_full_r;
    assign tx_data_o = tx_data_r;

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    // enabling a source with a stale flag raises irq at once; the
    // driver clears the flag first
    assign irq_o = (|(pend_a | pend_b)) & ctrl_r[PIF_CTRL_PERIPHERAL_IRQ_ENABLE] &
                   ctrl_r[PIF_CTRL_GIE];
endmodule

// file: logic/pif_pkg.sv
// package: offsets, field positions and reset values of the flag block
package pif_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] PIF_OFF_FLAGS_A = 8'h00;
    localparam logic [7:0] PIF_OFF_FLAGS_B = 8'h04;
    localparam logic [7:0] PIF_OFF_EN_A = 8'h08;
    localparam logic [7:0] PIF_OFF_EN_B = 8'h0c;
    localparam logic [7:0] PIF_OFF_CTRL = 8'h10;
    localparam logic [7:0] PIF_OFF_STAT = 8'h14;
    localparam logic [7:0] PIF_OFF_RXDATA = 8'h18;
    localparam logic [7:0] PIF_OFF_TXDATA = 8'h1c;
    localparam logic [7:0] PIF_OFF_PEND = 8'h20;
    // flags_a positions
    localparam int PIF_BIT_ADC = 6;
    localparam int PIF_BIT_RX = 5;
    localparam int PIF_BIT_TX = 4;
    localparam int PIF_BIT_SSP = 3;
    localparam int PIF_BIT_CCP = 2;
    localparam int PIF_BIT_PER = 1;
    localparam int PIF_BIT_OVF = 0;
    // flags_b positions
    localparam int PIF_BIT_OSC = 7;
    localparam int PIF_BIT_C2 = 6;
    localparam int PIF_BIT_C1 = 5;
    localparam int PIF_BIT_NV = 4;
    // implemented and software-writable bits
    localparam logic [7:0] PIF_MASK_A = 8'h7f;
    localparam logic [7:0] PIF_MASK_B = 8'hf0;
    localparam logic [7:0] PIF_WMASK_A = 8'h4f;
    // control register fields
    localparam int PIF_CTRL_GIE = 7;
    localparam int PIF_CTRL_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int PIF_CTRL_MODE_LSB = 0;
    // status register fields
    localparam int PIF_STAT_FIRST_COMPARATOR_OUTPUT = 0;
    localparam int PIF_STAT_SECOND_COMPARATOR_OUTPUT = 1;
    localparam int PIF_STAT_RXOVR = 2;
    localparam int PIF_STAT_TXFULL = 3;
    localparam int PIF_STAT_MODE_LSB = 4;
    // reset values
    localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
    localparam logic [7:0] PIF_RST_EN = 8'h00;
    localparam logic [7:0] PIF_RST_CTRL = 8'h00;
    localparam logic [7:0] PIF_RST_DATA = 8'h00;

    typedef enum logic [1:0] {
        PIF_CCP_OFF,
        PIF_CCP_CAPTURE,
        PIF_CCP_COMPARE,
        PIF_CCP_PWM
    } pif_ccp_mode_e;
endpackage

// file: logic/pif_evt_if.sv
// interface: raw peripheral events in, per-flag set pulses out
`timescale 1ns/1ps
interface pif_evt_if;
    import pif_pkg::*;
    logic adc_done;
    logic ssp_done;
    logic capture;
    logic match;
    logic period_match;
    logic overflow;
    logic osc_fail;
    logic nv_done;
    logic cmp1_out;
    logic cmp2_out;
    pif_ccp_mode_e ccp_mode;
    logic [7:0] set_a;
    logic [7:0] set_b;

    modport src(
        output adc_done, ssp_done, capture, match, period_match,
        output overflow, osc_fail, nv_done, cmp1_out, cmp2_out,
        output ccp_mode,
        input set_a, set_b
    );
    modport det(
        input adc_done, ssp_done, capture, match, period_match,
        input overflow, osc_fail, nv_done, cmp1_out, cmp2_out,
        input ccp_mode,
        output set_a, set_b
    );
endinterface

// file: logic/pif_event_detect.sv
// module: turns peripheral events into flag set requests
`timescale 1ns/1ps
module pif_event_detect
    import pif_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // events and set requests
    pif_evt_if.det evt
);
    logic cmp1_prev_r;
    logic cmp2_prev_r;
    logic primed_r;
    logic ccp_set;

    // first edge after reset only loads history, so a comparator
    // already high at release is not taken as a change
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmp1_prev_r <= 1'b0;
            cmp2_prev_r <= 1'b0;
            primed_r <= 1'b0;
        end else begin
            cmp1_prev_r <= evt.cmp1_out;
            cmp2_prev_r <= evt.cmp2_out;
            primed_r <= 1'b1;
        end
    end

    always_comb begin
        case (evt.ccp_mode)
            PIF_CCP_CAPTURE: ccp_set = evt.capture;
            PIF_CCP_COMPARE: ccp_set = evt.match;
            PIF_CCP_PWM: ccp_set = 1'b0;
            default: ccp_set = 1'b0;
        endcase
    end

    always_comb begin
        evt.set_a = 8'h00;
        evt.set_a[PIF_BIT_ADC] = evt.adc_done;
        evt.set_a[PIF_BIT_SSP] = evt.ssp_done;
        evt.set_a[PIF_BIT_CCP] = ccp_set;
        evt.set_a[PIF_BIT_PER] = evt.period_match;
        evt.set_a[PIF_BIT_OVF] = evt.overflow;
        evt.set_b = 8'h00;
        evt.set_b[PIF_BIT_OSC] = evt.osc_fail;
        evt.set_b[PIF_BIT_C2] = primed_r & (evt.cmp2_out ^ cmp2_prev_r);
        evt.set_b[PIF_BIT_C1] = primed_r & (evt.cmp1_out ^ cmp1_prev_r);
        evt.set_b[PIF_BIT_NV] = evt.nv_done;
    end
endmodule

// file: verification/pif_flags_checker.sv
// checker: bus timing and flag relations seen at the block's ports
`timescale 1ns/1ps
module pif_flags_checker
    import pif_pkg::*;
(
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // events
    input wire logic adc_done_i,
    input wire logic ssp_done_i,
    input wire logic capture_i,
    input wire logic compare_match_i,
    input wire logic period_match_i,
    input wire logic timer_overflow_i,
    input wire logic osc_fail_i,
    input wire logic nv_write_done_i,
    // transmit and interrupt
    input wire logic tx_take_i,
    input wire logic tx_full_o,
    input wire logic irq_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic [7:0] fa_r, fb_r, ctl_r;
    logic wr, rd, ha, hb, hc, ht, ccp;
    assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
    assign ha = wb_adr_i[7:2] == PIF_OFF_FLAGS_A[7:2];
    assign hb = wb_adr_i[7:2] == PIF_OFF_FLAGS_B[7:2];
    assign hc = wb_adr_i[7:2] == PIF_OFF_CTRL[7:2];
    assign ht = wb_adr_i[7:2] == PIF_OFF_TXDATA[7:2];
    assign ccp = capture_i && ctl_r[1:0] == 2'h1
        || compare_match_i && ctl_r[1:0] == 2'h2;
    // shadow of the writable flags except the two comparator flags; an event beats a clearing write
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fa_r <= 8'h00;
            fb_r <= 8'h00;
            ctl_r <= 8'h00;
        end else begin
            fa_r <= ({1'b0, adc_done_i, 2'h0, ssp_done_i, ccp,
                period_match_i, timer_overflow_i}
                | (wr && ha ? wb_dat_i[7:0] : fa_r)) & PIF_WMASK_A;
            fb_r <= ({osc_fail_i, 2'h0, nv_write_done_i, 4'h0}
                | (wr && hb ? wb_dat_i[7:0] : fb_r)) & 8'h90;
            if (wr && hc) begin
                ctl_r <= wb_dat_i[7:0];
            end
        end
    end
    AST_ACK_WAIT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack one cycle after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_FLAGS_A: assert property (rd && ha |->
        (wb_dat_o[7:0] & PIF_WMASK_A) == $past(fa_r))
        else $error("flags_a read differs from events");
    AST_FLAGS_B: assert property (rd && hb |->
        (wb_dat_o[7:0] & 8'h90) == $past(fb_r))
        else $error("flags_b read differs from events");
    AST_TX_EMPTY: assert property (rd && ha |->
        wb_dat_o[4] == !$past(tx_full_o))
        else $error("transmit empty flag wrong");
    AST_UNUSED_ZERO: assert property (rd |-> wb_dat_o[31:8] == 24'h0
        && !(ha && wb_dat_o[7]) && !(hb && |wb_dat_o[3:0]))
        else $error("unimplemented bit reads one");
    AST_TX_FILL: assert property (wr && ht |=> tx_full_o)
        else $error("buffer not full after transmit write");
    AST_TX_DRAIN: assert property (tx_take_i && tx_full_o
        && !(wr && ht) |=> !tx_full_o) else $error("buffer not drained");
    AST_IRQ_GATE: assert property (irq_o |-> ctl_r[7] && ctl_r[6])
        else $error("irq without both enables");
    AST_RESET_CLEAR: assert property ($rose(rstn_i) |->
        !irq_o && !tx_full_o && !wb_ack_o) else $error("busy after reset");
endmodule

bind pif_flags_top pif_flags_checker i_pif_flags_checker (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .adc_done_i(adc_done_i), .ssp_done_i(ssp_done_i),
    .capture_i(capture_i), .compare_match_i(compare_match_i),
    .period_match_i(period_match_i), .timer_overflow_i(timer_overflow_i),
    .osc_fail_i(osc_fail_i), .nv_write_done_i(nv_write_done_i),
    .tx_take_i(tx_take_i), .tx_full_o(tx_full_o), .irq_o(irq_o));

// file: verification/pif_periph_model.sv
// model: peripheral event sources, receiver and transmitter
`timescale 1ns/1ps
module pif_periph_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // transmit side of the block
    input wire logic tx_full_i,
    input wire logic [7:0] tx_data_i,
    input wire logic [3:0] tx_lag_i,
    // events, comparators, receiver, transmit drain
    output logic [7:0] evt_o,
    output logic [1:0] cmp_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic tx_take_o,
    output logic [7:0] tx_last_o
);
    logic [3:0] lag_r;
    initial begin
        evt_o = 8'h00;
        cmp_o = 2'h0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // bit order: adc ssp capture compare period overflow osc nv
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_i);
        evt_o <= m;
        @(posedge clk_i);
        evt_o <= 8'h00;
    endtask
    task automatic toggle(input int i);
        @(posedge clk_i);
        cmp_o[i] <= ~cmp_o[i];
    endtask
    // data line shows the inverse once the byte is no longer offered
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask
    // drains the held byte after tx_lag_i cycles, zero is prompt
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lag_r <= 4'h0;
            tx_take_o <= 1'b0;
            tx_last_o <= 8'h00;
        end else if (tx_full_i && !tx_take_o && lag_r == tx_lag_i) begin
            tx_take_o <= 1'b1;
            tx_last_o <= tx_data_i;
            lag_r <= 4'h0;
        end else begin
            tx_take_o <= 1'b0;
            lag_r <= (tx_full_i && !tx_take_o) ? lag_r + 4'h1 : 4'h0;
        end
    end
endmodule

// file: verification/pif_flags_bench.sv
// bench: drives the flag block over wishbone and the peripheral model
`timescale 1ns/1ps
module pif_flags_bench;
    import pif_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, m, evt, rxd, txd, txl;
    logic [3:0] sel = 4'h0, lag = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, rv;
    logic ack, irq, full, rxv, take;
    logic [1:0] cmp;
    int errors = 0, checks = 0, seed = 75, md;
    always #4 clk_i = ~clk_i;
    pif_flags_top i_pif_flags_top (.clk_i(clk_i), .rstn_i(rstn_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .adc_done_i(evt[0]), .ssp_done_i(evt[1]), .capture_i(evt[2]),
        .compare_match_i(evt[3]), .period_match_i(evt[4]),
        .timer_overflow_i(evt[5]), .osc_fail_i(evt[6]),
        .nv_write_done_i(evt[7]), .first_comparator_output_i(cmp[0]),
        .second_comparator_output_i(cmp[1]), .rx_valid_i(rxv),
        .rx_data_i(rxd), .tx_take_i(take), .tx_full_o(full),
        .tx_data_o(txd), .irq_o(irq));
    pif_periph_model i_pif_periph_model (.clk_i(clk_i), .rstn_i(rstn_i),
        .tx_full_i(full), .tx_data_i(txd), .tx_lag_i(lag), .evt_o(evt),
        .cmp_o(cmp), .rx_valid_o(rxv), .rx_data_o(rxd), .tx_take_o(take),
        .tx_last_o(txl));
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // ack is taken at the rising edge where it stands; the request is
    // released only after that edge
    task automatic wait_on(input int s);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 60 && !seen; i++) begin
            @(posedge clk_i);
            seen = ((s ? take : ack) === 1'b1);
        end
        chk(s ? "tx_take" : "wb_ack", 32'h1, {31'h0, seen});
        if (!seen) stop_test();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        wait_on(0);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(n, e, rv);
    endtask
    task automatic clr();
        bus(1'b1, PIF_OFF_FLAGS_A, 8'h00);
        bus(1'b1, PIF_OFF_FLAGS_B, 8'h00);
    endtask
    function automatic logic [31:0] exp_a(input logic [7:0] m, input int md);
        logic c;
        c = (m[2] && md == 1) || (m[3] && md == 2);
        return {25'h0, m[0], 2'b01, m[1], c, m[4], m[5]};
    endfunction
    initial begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdchk("flags_a", PIF_OFF_FLAGS_A, 32'h10);
        rdchk("flags_b", PIF_OFF_FLAGS_B, 32'h0);
        bus(1'b1, 8'h24, 8'hff);
        rdchk("hole", 8'h24, 32'h0);
        for (int k = 0; k < 28; k++) begin
            md = (k < 4) ? k : $unsigned($random(seed)) % 4;
            m = (k < 4) ? 8'hff : 8'($random(seed));
            bus(1'b1, PIF_OFF_CTRL, 8'(md));
            i_pif_periph_model.pulse(m);
            rdchk("flags_a", PIF_OFF_FLAGS_A, exp_a(m, md));
            rdchk("flags_b", PIF_OFF_FLAGS_B,
                {24'h0, m[6], 2'b0, m[7], 4'h0});
            clr();
            rdchk("cleared", PIF_OFF_FLAGS_A, 32'h10);
        end
        for (int i = 0; i < 2; i++) begin
            i_pif_periph_model.toggle(i);
            rdchk("cmp", PIF_OFF_FLAGS_B, 32'h20 << i);
            clr();
        end
        m = 8'($random(seed));
        i_pif_periph_model.send(m);
        bus(1'b1, PIF_OFF_FLAGS_A, 8'h00);
        rdchk("rx_flag", PIF_OFF_FLAGS_A, 32'h30);
        rdchk("rx_data", PIF_OFF_RXDATA, {24'h0, m});
        rdchk("rx_flag", PIF_OFF_FLAGS_A, 32'h10);
        // second byte while full is dropped and marks overrun
        i_pif_periph_model.send(m);
        i_pif_periph_model.send(~m);
        rdchk("stat", PIF_OFF_STAT, {26'h0, 2'(md), 4'b0111});
        rdchk("rx_data", PIF_OFF_RXDATA, {24'h0, m});
        bus(1'b1, PIF_OFF_STAT, 8'h04);
        rdchk("stat", PIF_OFF_STAT, {26'h0, 2'(md), 4'b0011});
        for (int i = 0; i < 2; i++) begin
            m = 8'($random(seed));
            bus(1'b1, PIF_OFF_TXDATA, m);
            // a prompt drain empties the buffer before a read could land
            if (i == 0) begin
                bus(1'b1, PIF_OFF_FLAGS_A, 8'h10);
                rdchk("tx_flag", PIF_OFF_FLAGS_A, 32'h0);
            end
            wait_on(1);
            chk("tx_byte", {24'h0, m}, {24'h0, txl});
            rdchk("tx_flag", PIF_OFF_FLAGS_A, 32'h10);
            lag <= 4'h0;
        end
        i_pif_periph_model.pulse(8'h01);
        bus(1'b1, PIF_OFF_EN_A, 8'h40);
        bus(1'b1, PIF_OFF_CTRL, 8'h80);
        @(negedge clk_i);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, PIF_OFF_CTRL, 8'hc0);
        @(negedge clk_i);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("pending", PIF_OFF_PEND, 32'h40);
        i_pif_periph_model.pulse(8'h40);
        clr();
        bus(1'b1, PIF_OFF_EN_B, 8'hff);
        @(negedge clk_i);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk("en_b", PIF_OFF_EN_B, 32'hf0);
        i_pif_periph_model.pulse(8'h80);
        @(negedge clk_i);
        chk("irq", 32'h1, {31'h0, irq});
        stop_test();
    end
endmodule
